// ---- src/pti_pkg.sv ----
/*
 * constants, carriers and companding helpers of the voice slot port.
 * assumes one 125 MHz pclk; link pins are asynchronous and resampled.
 */
// ============================================================
// Notes on behaviour
// - frame sync starts rx and tx frames
// - bit clock from transceiver times all bits
// - twelve slots of eight bits, 96 bits
// - bytes go msb first in slot
// - default drive rising, sample falling edge
// - per channel slot and line selection
// - rx and tx slots set independently
// - common delay 0..7, selectable sample edge
// - samples A-law or mu-law compressed
package pti_pkg;
    // ============================================================
    // sizes
    localparam int NCH = 4;                   // voice channels
    localparam logic [6:0] FRAME_BITS = 7'h60; // 96 bits per frame
    localparam logic [6:0] CNT_IDLE = 7'h7f;   // counter rest value
    // ============================================================
    // register map (byte addresses)
    localparam logic [11:0] ADR_SLOT_A = 12'h000; // tx slot per channel
    localparam logic [11:0] ADR_SLOT_B = 12'h004; // rx slot per channel
    localparam logic [11:0] ADR_TIMING = 12'h008; // common timing
    localparam logic [11:0] ADR_STATUS = 12'h00c; // read only state
    // per channel byte: [3:0] slot, [4] line, [5] enable
    localparam int F_LINE = 4;
    localparam int F_EN   = 5;
    // timing: [2:0] delay, [3] sample on rising, [4] A-law
    localparam int F_EDGE = 3;
    localparam int F_LAW  = 4;
    localparam logic [31:0] RST_SLOT   = 32'h0000_0000;
    localparam logic [4:0]  RST_TIMING = 5'h00;
    // synchroniser pin order
    localparam int P_BCL = 0;
    localparam int P_FS  = 1;
    localparam int P_MC  = 2;
    localparam int P_UP  = 3;
    localparam int P_DN  = 4;
    // ============================================================
    // user side carrier
    typedef struct packed {
        logic [NCH-1:0][15:0] sample;          // linear sample per channel
    } pti_voice_t;
    // ============================================================
    // linear to 8-bit compressed code
    function automatic logic [7:0] pti_compress(input logic [15:0] lin,
                                                input logic alaw);
        logic        sgn;
        logic [15:0] b;
        logic [2:0]  seg;
        logic [3:0]  man;
        sgn = lin[15];
        b   = sgn ? 16'(~lin + 16'h0001) : lin;
        seg = 3'h0;
        if (alaw) begin
            b = b >> 3;
            if (b > 16'h0fff) b = 16'h0fff;
            for (int i = 1; i < 8; i++) if (b[i+4]) seg = 3'(i);
            man = (seg == 3'h0) ? b[4:1] : 4'(b >> seg);
            return {~sgn, seg, man} ^ 8'h55;
        end
        b = (b >> 2) + 16'h0021;
        if (b > 16'h1fff) b = 16'h1fff;
        for (int i = 1; i < 8; i++) if (b[i+5]) seg = 3'(i);
        man = 4'(b >> (32'(seg) + 1));
        return ~{sgn, seg, man};
    endfunction : pti_compress
    // compressed code to linear
    function automatic logic [15:0] pti_expand(input logic [7:0] code,
                                               input logic alaw);
        logic [7:0]  c;
        logic [15:0] m;
        logic        neg;
        c = alaw ? (code ^ 8'h55) : ~code;
        m = {11'h000, c[3:0], 1'b0} + 16'h0021;
        if (alaw) begin
            neg = ~c[7];
            m = (c[6:4] == 3'h0) ? 16'({c[3:0], 1'b1} << 3)
                                 : 16'(m << (32'(c[6:4]) + 2));
        end else begin
            neg = c[7];
            m = 16'(((m << c[6:4]) - 16'h0021) << 2);
        end
        return neg ? 16'(~m + 16'h0001) : m;
    endfunction : pti_expand
endpackage : pti_pkg

// ---- src/pti_port.sv ----
/*
 * voice time slot port: resamples the link pins, counts bits from
 * frame sync, shifts compressed bytes in and out per channel, holds
 * the slot and timing registers behind an apb slave.
 * assumes the transceiver makes frame sync and clocks, and that the
 * bit clock is far slower than pclk.
 */
module pti_port (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // link clocks from the transceiver
    input  wire logic              bit_clock_in,
    input  wire logic              frame_sync,
    input  wire logic              master_clock_in,
    // two-way data lines
    input  wire logic              upstream_data_line_i,
    output logic                   upstream_data_line_o,
    output logic                   upstream_data_line_oe,
    input  wire logic              downstream_data_line_i,
    output logic                   downstream_data_line_o,
    output logic                   downstream_data_line_oe,
    // user side samples
    input  pti_pkg::pti_voice_t    tx_voice,
    output pti_pkg::pti_voice_t    rx_voice,
    output logic [pti_pkg::NCH-1:0] rx_valid,
    output logic                   frame_start
);
    // ============================================================
    // state
    typedef struct packed {
        logic [2:0][4:0]                  pin_s;    // sync chains
        logic [4:0]                       pin_f;    // agreed levels
        logic                             fs_prev;  // sync at last rise
        logic [6:0]                       cnt;      // bit in frame
        logic [31:0]                      cfg_tx;   // slot_config_a
        logic [31:0]                      cfg_rx;   // slot_config_b
        logic [4:0]                       timing;   // common timing
        logic [pti_pkg::NCH-1:0][7:0]     tx_byte;  // bytes to send
        logic [pti_pkg::NCH-1:0][7:0]     rx_shift; // bytes coming in
        logic [pti_pkg::NCH-1:0][15:0]    rx_lin;   // expanded samples
        logic [pti_pkg::NCH-1:0]          rx_vld;   // sample pulses
        logic                             frm;      // frame pulse
        logic                             mc_seen;  // master edge seen
        logic                             mc_act;   // master ran last frame
        logic [31:0]                      prdata;   // read data
        logic                             up_o;
        logic                             up_oe;
        logic                             dn_o;
        logic                             dn_oe;
    } pti_state_t;

    pti_state_t q;        // registered state
    pti_state_t d;        // next state
    logic       rise_w;   // bit clock rising
    logic       fall_w;   // bit clock falling
    logic       samp_w;   // sampling edge
    logic       fst_w;    // frame start at this rise
    logic       pv_w;     // current bit inside a slot
    logic [6:0] pos_w;    // delayed bit position
    logic       wr_w;     // apb write access

    // ============================================================
    // helpers
    // slot position of a counter value after the common delay
    function automatic logic [6:0] slot_pos(input logic [6:0] c,
                                            input logic [2:0] dl);
        return c - {4'h0, dl};
    endfunction : slot_pos
    function automatic logic pos_ok(input logic [6:0] c,
                                    input logic [2:0] dl);
        return (c >= {4'h0, dl}) && (slot_pos(c, dl) < pti_pkg::FRAME_BITS);
    endfunction : pos_ok
    function automatic logic addr_ok(input logic [11:0] a);
        return (a[11:4] == 8'h00) && (a[1:0] == 2'b00);
    endfunction : addr_ok

    // ============================================================
    // next state
    always_comb begin
        logic [6:0]  ncnt;
        logic [6:0]  np;
        logic [7:0]  cf;
        logic        bitv;
        logic [7:0]  full;
        ncnt = q.cnt;
        np   = 7'h00;
        cf   = 8'h00;
        bitv = 1'b0;
        full = 8'h00;
        d    = q;
        d.rx_vld = '0;
        d.frm    = 1'b0;
        // three flops; a change counts when the last two agree
        d.pin_s = {q.pin_s[1:0], {downstream_data_line_i, upstream_data_line_i,
                   master_clock_in, frame_sync, bit_clock_in}};
        for (int i = 0; i < 5; i++) begin
            if (q.pin_s[1][i] == q.pin_s[2][i]) begin
                d.pin_f[i] = q.pin_s[2][i];
            end
        end
        rise_w = d.pin_f[pti_pkg::P_BCL] & ~q.pin_f[pti_pkg::P_BCL];
        fall_w = ~d.pin_f[pti_pkg::P_BCL] & q.pin_f[pti_pkg::P_BCL];
        // default samples on falling, option on the next rising
        samp_w = q.timing[pti_pkg::F_EDGE] ? rise_w : fall_w;
        fst_w  = rise_w & q.pin_f[pti_pkg::P_FS] & ~q.fs_prev;
        pv_w   = pos_ok(q.cnt, q.timing[2:0]);
        pos_w  = slot_pos(q.cnt, q.timing[2:0]);
        // receive: shift the selected line in during own slot
        if (samp_w && pv_w) begin
            for (int ch = 0; ch < pti_pkg::NCH; ch++) begin
                cf = q.cfg_rx[ch*8 +: 8];
                if (cf[pti_pkg::F_EN] && cf[3:0] == pos_w[6:3]) begin
                    bitv = cf[pti_pkg::F_LINE] ? q.pin_f[pti_pkg::P_DN]
                                               : q.pin_f[pti_pkg::P_UP];
                    full = {q.rx_shift[ch][6:0], bitv};
                    d.rx_shift[ch] = full;
                    if (pos_w[2:0] == 3'h7) begin
                        // expand on the eighth bit
                        d.rx_lin[ch] = pti_pkg::pti_expand(full,
                                           q.timing[pti_pkg::F_LAW]);
                        d.rx_vld[ch] = 1'b1;
                    end
                end
            end
        end
        // master clock activity over one frame
        if (d.pin_f[pti_pkg::P_MC] & ~q.pin_f[pti_pkg::P_MC]) begin
            d.mc_seen = 1'b1;
        end else if (fst_w) begin
            d.mc_seen = 1'b0;
        end
        // transmit: advance counter and drive on the rising edge
        if (rise_w) begin
            d.fs_prev = q.pin_f[pti_pkg::P_FS];
            if (fst_w) begin
                ncnt  = 7'h00;
                d.frm = 1'b1;
                d.mc_act = q.mc_seen;
                for (int ch = 0; ch < pti_pkg::NCH; ch++) begin
                    d.tx_byte[ch] = pti_pkg::pti_compress(tx_voice.sample[ch],
                                        q.timing[pti_pkg::F_LAW]);
                end
            end else if (q.cnt != pti_pkg::CNT_IDLE) begin
                ncnt = q.cnt + 7'h01;
            end
            d.cnt   = ncnt;
            np      = slot_pos(ncnt, q.timing[2:0]);
            d.up_oe = 1'b0;
            d.dn_oe = 1'b0;
            if (pos_ok(ncnt, q.timing[2:0])) begin
                for (int ch = 0; ch < pti_pkg::NCH; ch++) begin
                    cf = q.cfg_tx[ch*8 +: 8];
                    if (cf[pti_pkg::F_EN] && cf[3:0] == np[6:3]) begin
                        bitv = d.tx_byte[ch][3'h7 - np[2:0]];
                        if (cf[pti_pkg::F_LINE]) begin
                            d.dn_o  = bitv;
                            d.dn_oe = 1'b1;
                        end else begin
                            d.up_o  = bitv;
                            d.up_oe = 1'b1;
                        end
                    end
                end
            end
        end
        // apb write takes effect in the access cycle
        wr_w = psel & penable & pwrite;
        if (wr_w) begin
            unique case (paddr)
                pti_pkg::ADR_SLOT_A: d.cfg_tx = pwdata;
                pti_pkg::ADR_SLOT_B: d.cfg_rx = pwdata;
                pti_pkg::ADR_TIMING: d.timing = pwdata[4:0];
                default: ;
            endcase
        end
        // apb read data prepared in the setup cycle
        if (psel && !penable) begin
            unique case (paddr)
                pti_pkg::ADR_SLOT_A: d.prdata = q.cfg_tx;
                pti_pkg::ADR_SLOT_B: d.prdata = q.cfg_rx;
                pti_pkg::ADR_TIMING: d.prdata = {27'h0, q.timing};
                pti_pkg::ADR_STATUS: d.prdata = {23'h0, q.mc_act,
                                                 q.pin_f[pti_pkg::P_FS], q.cnt};
                default:             d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.cnt    <= pti_pkg::CNT_IDLE;
            q.cfg_tx <= pti_pkg::RST_SLOT;
            q.cfg_rx <= pti_pkg::RST_SLOT;
            q.timing <= pti_pkg::RST_TIMING;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // outputs
    assign prdata                  = q.prdata;
    assign pready                  = 1'b1;
    assign pslverr                 = psel & penable & ~addr_ok(paddr);
    assign upstream_data_line_o    = q.up_o;
    assign upstream_data_line_oe   = q.up_oe;
    assign downstream_data_line_o  = q.dn_o;
    assign downstream_data_line_oe = q.dn_oe;
    assign rx_voice.sample         = q.rx_lin;
    assign rx_valid                = q.rx_vld;
    assign frame_start             = q.frm;

    // ============================================================
    // checks
    AST_FRAME_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        fst_w |=> (q.cnt == 7'h00) && q.frm)
        else $error("frame sync did not restart bit count");
    AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (rise_w && !fst_w && q.cnt < 7'h7e) |=> q.cnt == $past(q.cnt) + 7'h01)
        else $error("bit counter did not advance by one");
    AST_COUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!rise_w && !fst_w) |=> $stable(q.cnt))
        else $error("bit counter moved without bit clock");
    AST_DRIVE_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(q.up_oe) || $rose(q.dn_oe) |-> $past(rise_w))
        else $error("line enabled away from rising bit edge");
    AST_SAMPLE_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        (|q.rx_vld) |-> $past(samp_w) && $past(pv_w))
        else $error("sample taken away from sampling edge");
    AST_IN_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
        (q.up_oe || q.dn_oe) && $stable(q.timing) |-> pv_w)
        else $error("line driven outside frame slots");
    AST_MSB_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        rise_w && q.cfg_tx[5] && !q.cfg_tx[4] && !fst_w && q.cnt != pti_pkg::CNT_IDLE
        && pos_ok(q.cnt + 7'h01, q.timing[2:0])
        && slot_pos(q.cnt + 7'h01, q.timing[2:0]) == {q.cfg_tx[3:0], 3'h0}
        |=> q.up_oe && q.up_o == q.tx_byte[0][7])
        else $error("slot did not open with the top bit");
    AST_CFG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_w && paddr == pti_pkg::ADR_SLOT_B |=> q.cfg_rx == $past(pwdata)
        && $stable(q.cfg_tx))
        else $error("receive slot write lost or leaked");
    AST_EXPAND: assert property (@(posedge pclk) disable iff (!presetn)
        q.rx_vld[1] && $stable(q.timing) |-> q.rx_lin[1]
        == pti_pkg::pti_expand(q.rx_shift[1], q.timing[pti_pkg::F_LAW]))
        else $error("received byte not expanded");
    COV_FRAME: cover property (@(posedge pclk) disable iff (!presetn) fst_w);
    COV_RX: cover property (@(posedge pclk) disable iff (!presetn) |q.rx_vld);
    COV_UP: cover property (@(posedge pclk) disable iff (!presetn) $rose(q.up_oe));
    COV_DN: cover property (@(posedge pclk) disable iff (!presetn) $rose(q.dn_oe));
endmodule : pti_port

// ---- testbench/pti_xcvr_model.sv ----
/*
 * line transceiver model: makes bit clock, frame sync and master clock,
 * sends one byte per frame toward the port, records the port's drive.
 * assumes a 125 MHz pclk; the port resamples every link pin itself.
 */
module pti_xcvr_model (
    // host clock
    input  wire logic        pclk,
    // link clocks
    output logic             bit_clock_in,
    output logic             frame_sync,
    output logic             master_clock_in,
    // line levels while the port is off the line
    output logic             up_val,
    output logic             dn_val,
    // port drive
    input  wire logic        up_o,
    input  wire logic        up_oe,
    input  wire logic        dn_o,
    input  wire logic        dn_oe,
    // byte sent toward the port
    input  wire logic [7:0]  rx_code,
    input  wire logic [6:0]  rx_pos,
    input  wire logic        rx_dn,
    // record of the last frame
    output logic [95:0]      up_seen,
    output logic [95:0]      up_drv,
    output logic [95:0]      dn_seen,
    output logic [95:0]      dn_drv,
    output int               frame_cnt,
    output int               clash_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt  = 0;   // pclk count within a half bit
    int   len  = 81;  // 81 or 82 cycles, 81.375 on average
    int   acc  = 0;   // carried fraction, in eighths of a cycle
    int   bitn = 95;  // bit index within the frame
    int   hold = -1;  // cycles left until our data changes
    logic in_slot;    // current bit lies in the byte we send
    assign in_slot = bitn >= rx_pos && bitn < rx_pos + 8;
    // all pins start low
    initial begin
        {bit_clock_in, frame_sync, master_clock_in, up_val, dn_val} = 5'h00;
        {up_seen, up_drv, dn_seen, dn_drv} = '0;
        frame_cnt = 0;
        clash_cnt = 0;
    end
    // ============================================================
    // clocks, frame sync and line traffic
    always @(posedge pclk) begin
        cnt = cnt + 1;
        if (cnt == len / 2) master_clock_in <= ~master_clock_in;
        if (cnt == len) begin
            cnt = 0;
            acc = acc + 3;
            len = (acc >= 8) ? 82 : 81;
            acc = acc % 8;
            master_clock_in <= ~master_clock_in;
            bit_clock_in <= ~bit_clock_in;
            if (!bit_clock_in) begin
                // rising edge: next bit, our data follows after a hold time
                bitn = (bitn + 1) % 96;
                hold = 20;
            end else begin
                // falling edge: record what the port puts on each line
                up_seen[bitn] <= up_o;
                up_drv[bitn]  <= up_oe;
                dn_seen[bitn] <= dn_o;
                dn_drv[bitn]  <= dn_oe;
                if (in_slot && (rx_dn ? dn_oe : up_oe)) clash_cnt <= clash_cnt + 1;
                frame_sync <= (bitn == 95);
                if (bitn == 95) frame_cnt <= frame_cnt + 1;
            end
        end
        // byte msb first, elsewhere the inverse of the last level
        if (hold == 0) begin
            up_val <= (in_slot && !rx_dn) ? rx_code[7 - (bitn - rx_pos)] : ~up_val;
            dn_val <= (in_slot && rx_dn) ? rx_code[7 - (bitn - rx_pos)] : ~dn_val;
        end
        hold = hold - 1;
    end
endmodule : pti_xcvr_model

// ---- testbench/pcm_timeslot_interface_tb.sv ----
/*
 * self-checking bench of the voice slot port: apb master tasks,
 * transceiver model on the link, one task per scenario.
 * assumes pti_pkg, pti_port and pti_xcvr_model are compiled first.
 */
module pcm_timeslot_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // apb side
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata;
    // link pins, wire level from both ends
    logic                      bit_clock_in, frame_sync, master_clock_in, up_val, dn_val;
    logic                      upstream_data_line_o, upstream_data_line_oe;
    logic                      downstream_data_line_o, downstream_data_line_oe;
    wire upstream_data_line_i = upstream_data_line_oe ? upstream_data_line_o : up_val;
    wire downstream_data_line_i = downstream_data_line_oe ? downstream_data_line_o : dn_val;
    // user side
    pti_pkg::pti_voice_t       tx_voice, rx_voice;
    logic [pti_pkg::NCH-1:0]   rx_valid;
    logic                      frame_start;
    // model control and record
    logic [7:0]                rx_code;
    logic [6:0]                rx_pos;
    logic                      rx_dn;
    logic [95:0]               up_seen, up_drv, dn_seen, dn_drv;
    int                        frame_cnt, clash_cnt;
    // bookkeeping
    int err_count = 0, checks_done = 0, cyc = 0, fs_seen = 0, rv_seen = 0, rv_bad = 0;
    pti_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bit_clock_in, .frame_sync, .master_clock_in,
        .upstream_data_line_i, .upstream_data_line_o, .upstream_data_line_oe,
        .downstream_data_line_i, .downstream_data_line_o, .downstream_data_line_oe,
        .tx_voice, .rx_voice, .rx_valid, .frame_start);
    pti_xcvr_model xcvr (.pclk, .bit_clock_in, .frame_sync, .master_clock_in, .up_val,
        .dn_val, .up_o(upstream_data_line_o), .up_oe(upstream_data_line_oe),
        .dn_o(downstream_data_line_o), .dn_oe(downstream_data_line_oe), .rx_code, .rx_pos,
        .rx_dn, .up_seen, .up_drv, .dn_seen, .dn_drv, .frame_cnt, .clash_cnt);
    // ============================================================
    // clock, hang guard and pulse counters
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (frame_start === 1'b1) fs_seen++;
        if (rx_valid[1] === 1'b1) rv_seen++;
        if ((rx_valid & 4'hd) !== 4'h0) rv_bad++;
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end
    // ============================================================
    // shared tasks
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no limit of its own; pready ends this wait, the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask : wr
    // returns just after the model closes a frame
    task automatic wait_frame();
        int old;
        old = frame_cnt;
        for (int n = 0; n < 20000 && frame_cnt == old; n++) @(posedge pclk);
    endtask : wait_frame
    // byte at frame bit st, msb first
    function automatic logic [95:0] place(input logic [7:0] c, input int st);
        logic [95:0] v;
        v = '0;
        for (int i = 0; i < 8; i++) v[st + i] = c[7 - i];
        return v;
    endfunction : place
    // ============================================================
    // scenarios
    task automatic t_reset_map();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 3; i++) begin
            apb(12'(4 * i), 1'b0, 32'h0000_0000, r, e);
            chk({r, e}, {pti_pkg::RST_SLOT, 1'b0});
        end
        apb(12'h010, 1'b1, 32'hffff_ffff, r, e);
        chk(e, 1'b1);
        apb(12'h010, 1'b0, 32'h0000_0000, r, e);
        chk({r, e}, {32'h0000_0000, 1'b1});
        apb(pti_pkg::ADR_STATUS, 1'b1, 32'hffff_ffff, r, e);
        chk(e, 1'b0);
        wait_frame();
        chk(up_drv | dn_drv, 96'h0);
    endtask : t_reset_map
    // mu-law, no delay, falling sample, slot 11 at the frame end
    task automatic t_mu_delay0();
        tx_voice.sample[0] <= 16'h7fff;
        tx_voice.sample[3] <= 16'h0000;
        rx_code <= 8'h80;
        rx_pos <= 7'h10;
        rx_dn <= 1'b1;
        wr(pti_pkg::ADR_TIMING, 32'h0000_0000);
        wr(pti_pkg::ADR_SLOT_A, 32'h3b00_0020);
        wr(pti_pkg::ADR_SLOT_B, 32'h0000_3200);
        fs_seen = 0;
        rv_seen = 0;
        rv_bad = 0;
        wait_frame();
        chk(up_drv, place(8'hff, 0));
        chk(up_seen & up_drv, place(8'h80, 0));
        chk(dn_drv, place(8'hff, 88));
        chk(dn_seen & dn_drv, place(8'hff, 88));
        chk(rx_voice.sample[1], 16'h7d7c);
        chk({fs_seen[7:0], rv_seen[7:0], rv_bad[7:0]}, 24'h01_01_00);
    endtask : t_mu_delay0
    // A-law, delay 7, rising sample, master clock activity
    task automatic t_alaw_delay7();
        logic [31:0] r;
        logic        e;
        rx_code <= 8'hd5;
        rx_pos <= 7'h17;
        wr(pti_pkg::ADR_TIMING, 32'h0000_001f);
        wr(pti_pkg::ADR_SLOT_A, 32'h3a00_0020);
        rv_seen = 0;
        wait_frame();
        chk(up_drv, place(8'hff, 7));
        chk(up_seen & up_drv, place(8'haa, 7));
        chk(dn_drv, place(8'hff, 87));
        chk(dn_seen & dn_drv, place(8'hd5, 87));
        chk(rx_voice.sample[1], 16'h0008);
        chk({rv_seen[7:0], 8'(clash_cnt)}, 16'h0100);
        apb(pti_pkg::ADR_STATUS, 1'b0, 32'h0000_0000, r, e);
        chk(r[8], 1'b1);
    endtask : t_alaw_delay7
    // ============================================================
    // verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, rx_dn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        tx_voice = '0;
        rx_code = 8'h00;
        rx_pos = 7'h7f;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        t_mu_delay0();
        t_alaw_delay7();
        summarize();
    end
endmodule : pcm_timeslot_interface_tb
